// ==== verilog/mics_pkg.sv ====
// constants for the metering interrupt status and calibration mode block
package mics_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] MICS_CAL_IDX = 8'h3D;
    localparam logic [7:0] MICS_ENL_IDX = 8'hD9;
    localparam logic [7:0] MICS_ENM_IDX = 8'hDA;
    localparam logic [7:0] MICS_ENH_IDX = 8'hDB;
    localparam logic [7:0] MICS_STL_IDX = 8'hDC;
    localparam logic [7:0] MICS_STM_IDX = 8'hDD;
    localparam logic [7:0] MICS_STH_IDX = 8'hDE;

    // calibration mode fields
    localparam int MICS_SEL_LSB = 4;
    localparam int MICS_VSHORT_BIT = 3;
    localparam int MICS_ISHORT_BIT = 2;
    localparam logic [1:0] MICS_SEL_FORCE_A = 2'h1;
    localparam logic [1:0] MICS_SEL_FORCE_B = 2'h2;
    localparam logic [7:0] MICS_CAL_WMASK = 8'h3C;

    // status fields
    localparam int MICS_SUMMARY_BIT = 7;
    localparam int MICS_RESET_BIT = 7;
    localparam logic [7:0] MICS_STL_MASK = 8'h3F;
    localparam logic [7:0] MICS_STM_MASK = 8'hFF;
    localparam logic [7:0] MICS_STH_MASK = 8'hBF;
    localparam logic [7:0] MICS_ENL_MASK = 8'h3F;
    localparam logic [7:0] MICS_ENH_MASK = 8'h3F;

    // reset values
    localparam logic [7:0] MICS_REG_RST = 8'h00;

    // axi responses
    localparam logic [1:0] MICS_RESP_OKAY = 2'h0;
    localparam logic [1:0] MICS_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MICS_R_CAL,
        MICS_R_ENL,
        MICS_R_ENM,
        MICS_R_ENH,
        MICS_R_STL,
        MICS_R_STM,
        MICS_R_STH,
        MICS_R_NONE
    } mics_reg_t;
endpackage : mics_pkg

// ==== verilog/mics_top.sv ====
// metering interrupt status flags, enables and calibration mode behind axi4-lite
// How it works
// [RQ1] software writes zero to calibration mode bits 7:6 and 1:0
// [RQ2] select field 01 forces input a, 10 input b, else tamper logic chooses
// [RQ3] voltage short bit one grounds the voltage channel input
// [RQ4] current short bit one grounds the current channel input
// [RQ5] summary bit set while any enabled flag is set, clears when none
// [RQ6] fault change flag set on fault change in configured direction
// [RQ7] reactive sign flag set on reactive sign change in configured direction
// [RQ8] active sign flag set on active sign change in configured direction
// [RQ9] apparent no-load flag set on apparent no-load or rms no-load entry
// [RQ10] reactive no-load flag set on reactive no-load detection
// [RQ11] active no-load flag set on active no-load detection
// [RQ12] pulse output two flag set on every pulse, enabled or not
// [RQ13] pulse output one flag set on every pulse, enabled or not
// [RQ14] overflow flags for apparent, reactive, active accumulators at bits 5,4,3
// [RQ15] half-full flags for apparent, reactive, active accumulators at bits 2,1,0
// [RQ16] reset done flag set at end of hardware or software reset
// [RQ17] waveform ready flag set when new waveform samples are loaded
// [RQ18] current peak flag set when current exceeds its peak level
// [RQ19] voltage peak flag set when voltage exceeds its peak level
// [RQ20] cycle end flag set when half line cycle accumulation completes
// [RQ21] zero cross timeout flag set when no crossing during timeout count
// [RQ22] zero cross flag set on each voltage zero crossing
// [RQ23] fault direction zero fires on fault entry, one on normal return
// [RQ24] sign direction zero fires on positive to negative, one on reverse
// [RQ25] each flag except reset done has an enable; enabled set flag raises pending request
// [RQ26] flags stay set until software writes zero; other bits unchanged
`timescale 1ns/1ps
`default_nettype none
module mics_top
    import mics_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // accumulation mode direction bits
    input wire logic fault_dir,
    input wire logic reactive_sign_dir,
    input wire logic active_sign_dir,
    // metering state levels
    input wire logic fault_mode,
    input wire logic reactive_power_negative,
    input wire logic active_power_negative,
    // metering event pulses
    input wire logic apparent_noload_evt,
    input wire logic irms_noload_entry_evt,
    input wire logic reactive_noload_evt,
    input wire logic active_noload_evt,
    input wire logic pulse_out_two_evt,
    input wire logic pulse_out_one_evt,
    input wire logic apparent_overflow_evt,
    input wire logic reactive_overflow_evt,
    input wire logic active_overflow_evt,
    input wire logic apparent_halffull_evt,
    input wire logic reactive_halffull_evt,
    input wire logic active_halffull_evt,
    input wire logic soft_reset_done_evt,
    input wire logic waveform_load_evt,
    input wire logic current_peak_evt,
    input wire logic voltage_peak_evt,
    input wire logic cycle_end_evt,
    input wire logic zero_cross_timeout_evt,
    input wire logic zero_cross_evt,
    // tamper logic choice, one selects input b
    input wire logic tamper_select_b,
    // analog front end control
    output logic current_use_b,
    output logic voltage_ch_grounded,
    output logic current_ch_grounded,
    // pending request to the core
    output logic metering_irq_pending
);

    function automatic mics_reg_t mics_decode(input logic [ADDR_W-1:0] addr);
        mics_reg_t r;
        r = MICS_R_NONE;
        if (addr[1:0] == 2'h0 && addr[ADDR_W-1:10] == '0) begin
            unique case (addr[9:2])
                MICS_CAL_IDX: r = MICS_R_CAL;
                MICS_ENL_IDX: r = MICS_R_ENL;
                MICS_ENM_IDX: r = MICS_R_ENM;
                MICS_ENH_IDX: r = MICS_R_ENH;
                MICS_STL_IDX: r = MICS_R_STL;
                MICS_STM_IDX: r = MICS_R_STM;
                MICS_STH_IDX: r = MICS_R_STH;
                default: r = MICS_R_NONE;
            endcase
        end
        return r;
    endfunction : mics_decode

    // a written zero clears, a written one keeps; a same-cycle set always wins
    function automatic logic [7:0] mics_flag_next(input logic [7:0] cur, input logic wr,
            input logic [7:0] wdat, input logic [7:0] set, input logic [7:0] mask);
        logic [7:0] keep;
        keep = wr ? wdat : 8'hFF;
        return ((cur & keep) | set) & mask;
    endfunction : mics_flag_next

    logic [ADDR_W-1:0] aw_addr_reg;
    logic aw_held_reg;
    logic [7:0] w_data_reg;
    logic w_en_reg;
    logic w_held_reg;
    logic [7:0] cal_reg;
    logic [7:0] enl_reg;
    logic [7:0] enm_reg;
    logic [7:0] enh_reg;
    logic [7:0] stl_reg;
    logic [7:0] stm_reg;
    logic [7:0] sth_reg;
    logic [7:0] stl_next;
    logic [7:0] stm_next;
    logic [7:0] sth_next;
    logic fault_prev_reg;
    logic react_prev_reg;
    logic act_prev_reg;
    logic reset_done_reg;
    logic summary;
    logic wr_go;
    mics_reg_t wr_sel;
    logic [7:0] set_l;
    logic [7:0] set_m;
    logic [7:0] set_h;
    logic fault_evt;
    logic react_evt;
    logic act_evt;
    logic [7:0] st_low_view;

    // write channel acceptance, address and data in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_sel = mics_decode(aw_addr_reg);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_held_reg <= 1'b0;
            w_data_reg <= MICS_REG_RST;
            w_en_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_en_reg <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MICS_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == MICS_R_NONE) ? MICS_RESP_SLVERR : MICS_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // writable configuration; reserved calibration bits are dropped
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_reg <= MICS_REG_RST;
            enl_reg <= MICS_REG_RST;
            enm_reg <= MICS_REG_RST;
            enh_reg <= MICS_REG_RST;
        end else if (wr_go && w_en_reg) begin
            unique case (wr_sel)
                MICS_R_CAL: cal_reg <= w_data_reg & MICS_CAL_WMASK; // [RQ1]
                MICS_R_ENL: enl_reg <= w_data_reg & MICS_ENL_MASK; // [RQ25]
                MICS_R_ENM: enm_reg <= w_data_reg; // [RQ25]
                MICS_R_ENH: enh_reg <= w_data_reg & MICS_ENH_MASK; // [RQ25]
                default: ;
            endcase
        end
    end

    // front end steering
    always_comb begin
        unique case (cal_reg[MICS_SEL_LSB +: 2])
            MICS_SEL_FORCE_A: current_use_b = 1'b0; // [RQ2]
            MICS_SEL_FORCE_B: current_use_b = 1'b1; // [RQ2]
            default: current_use_b = tamper_select_b; // [RQ2]
        endcase
    end
    assign voltage_ch_grounded = cal_reg[MICS_VSHORT_BIT]; // [RQ3]
    assign current_ch_grounded = cal_reg[MICS_ISHORT_BIT]; // [RQ4]

    // previous levels for direction-qualified change detection
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_prev_reg <= 1'b0;
            react_prev_reg <= 1'b0;
            act_prev_reg <= 1'b0;
        end else begin
            fault_prev_reg <= fault_mode;
            react_prev_reg <= reactive_power_negative;
            act_prev_reg <= active_power_negative;
        end
    end

    // entry edge when direction is zero, return edge when one
    assign fault_evt = fault_dir ? (fault_prev_reg && !fault_mode)
                                 : (!fault_prev_reg && fault_mode); // [RQ6] [RQ23]
    assign react_evt = reactive_sign_dir ? (react_prev_reg && !reactive_power_negative)
                                         : (!react_prev_reg && reactive_power_negative); // [RQ7]
    assign act_evt = active_sign_dir ? (act_prev_reg && !active_power_negative)
                                     : (!act_prev_reg && active_power_negative); // [RQ8] [RQ24]

    // first edge after reset release marks the end of a hardware reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_done_reg <= 1'b0;
        end else begin
            reset_done_reg <= 1'b1;
        end
    end

    always_comb begin
        set_l = 8'h00;
        set_l[5] = fault_evt; // [RQ6]
        set_l[4] = react_evt; // [RQ7]
        set_l[3] = act_evt; // [RQ8]
        set_l[2] = apparent_noload_evt || irms_noload_entry_evt; // [RQ9]
        set_l[1] = reactive_noload_evt; // [RQ10]
        set_l[0] = active_noload_evt; // [RQ11]
        set_m = {pulse_out_two_evt, // [RQ12]
                 pulse_out_one_evt, // [RQ13]
                 apparent_overflow_evt, reactive_overflow_evt, active_overflow_evt, // [RQ14]
                 apparent_halffull_evt, reactive_halffull_evt, active_halffull_evt}; // [RQ15]
        set_h = 8'h00;
        set_h[MICS_RESET_BIT] = !reset_done_reg || soft_reset_done_evt; // [RQ16]
        set_h[5] = waveform_load_evt; // [RQ17]
        set_h[4] = current_peak_evt; // [RQ18]
        set_h[3] = voltage_peak_evt; // [RQ19]
        set_h[2] = cycle_end_evt; // [RQ20]
        set_h[1] = zero_cross_timeout_evt; // [RQ21]
        set_h[0] = zero_cross_evt; // [RQ22]
    end

    always_comb begin
        stl_next = mics_flag_next(stl_reg, wr_go && w_en_reg && wr_sel == MICS_R_STL,
                                  w_data_reg, set_l, MICS_STL_MASK); // [RQ26]
        stm_next = mics_flag_next(stm_reg, wr_go && w_en_reg && wr_sel == MICS_R_STM,
                                  w_data_reg, set_m, MICS_STM_MASK); // [RQ26]
        sth_next = mics_flag_next(sth_reg, wr_go && w_en_reg && wr_sel == MICS_R_STH,
                                  w_data_reg, set_h, MICS_STH_MASK); // [RQ26]
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stl_reg <= MICS_REG_RST;
            stm_reg <= MICS_REG_RST;
            sth_reg <= MICS_REG_RST;
        end else begin
            stl_reg <= stl_next;
            stm_reg <= stm_next;
            sth_reg <= sth_next;
        end
    end

    // reset flag has no enable bit, so it never feeds the summary
    assign summary = |(stl_reg & enl_reg) || |(stm_reg & enm_reg)
                     || |(sth_reg & enh_reg); // [RQ5] [RQ25]
    assign metering_irq_pending = summary; // [RQ25]
    always_comb begin
        st_low_view = stl_reg;
        st_low_view[MICS_SUMMARY_BIT] = summary; // [RQ5]
    end

    // read channel, one outstanding read, data registered
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= MICS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= MICS_RESP_OKAY;
            unique case (mics_decode(s_axi_araddr))
                MICS_R_CAL: s_axi_rdata <= {24'h000000, cal_reg};
                MICS_R_ENL: s_axi_rdata <= {24'h000000, enl_reg};
                MICS_R_ENM: s_axi_rdata <= {24'h000000, enm_reg};
                MICS_R_ENH: s_axi_rdata <= {24'h000000, enh_reg};
                MICS_R_STL: s_axi_rdata <= {24'h000000, st_low_view};
                MICS_R_STM: s_axi_rdata <= {24'h000000, stm_reg};
                MICS_R_STH: s_axi_rdata <= {24'h000000, sth_reg};
                MICS_R_NONE: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= MICS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : mics_top
`default_nettype wire

// ==== testbench/mics_checker.sv ====
// port checker for the metering status and calibration mode block
`timescale 1ns/1ps
`default_nettype none
module mics_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // metering side
    input wire logic tamper_select_b,
    input wire logic current_use_b,
    input wire logic voltage_ch_grounded,
    input wire logic current_ch_grounded,
    input wire logic metering_irq_pending
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    ground_on_write_a: assert property (
        $changed({voltage_ch_grounded, current_ch_grounded}) |-> s_axi_bvalid)
        else $error("ground control moved without a write");
    select_cause_a: assert property (
        $changed(current_use_b) |-> s_axi_bvalid || $changed(tamper_select_b))
        else $error("channel choice moved without cause");
    pending_sticky_a: assert property ($fell(metering_irq_pending) |-> s_axi_bvalid)
        else $error("pending dropped without a write");
endmodule : mics_checker
bind mics_top mics_checker u_chk (.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .tamper_select_b,
    .current_use_b, .voltage_ch_grounded, .current_ch_grounded, .metering_irq_pending);
`default_nettype wire

// ==== testbench/mics_event_src.sv ====
// metering signal processor model: registers requests into event pulses one cycle later
`timescale 1ns/1ps
`default_nettype none
module mics_event_src (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // requested events and their pulses
    input wire logic [18:0] req,
    output logic [18:0] evt
);
    // registered so pulses launch cleanly after an edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) evt <= '0;
        else evt <= req;
    end
endmodule : mics_event_src
`default_nettype wire

// ==== testbench/test_metering_irq_status_calibration_mode.sv ====
// self-checking bench for the metering status and calibration mode block
`timescale 1ns/1ps
`default_nettype none
module test_metering_irq_status_calibration_mode
    import mics_pkg::*;
;
    localparam logic [11:0] A_CAL = {2'h0, MICS_CAL_IDX, 2'h0};
    localparam logic [11:0] A_ENL = {2'h0, MICS_ENL_IDX, 2'h0};
    localparam logic [11:0] A_ENM = {2'h0, MICS_ENM_IDX, 2'h0};
    localparam logic [11:0] A_ENH = {2'h0, MICS_ENH_IDX, 2'h0};
    localparam logic [11:0] A_STL = {2'h0, MICS_STL_IDX, 2'h0};
    localparam logic [11:0] A_STM = {2'h0, MICS_STM_IDX, 2'h0};
    localparam logic [11:0] A_STH = {2'h0, MICS_STH_IDX, 2'h0};
    logic sys_clk = 1'h0, reset_n = 1'h0, tamper_select_b = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, dir = '0, lvl = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic current_use_b, voltage_ch_grounded, current_ch_grounded, metering_irq_pending;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [18:0] req = '0, evt;
    int errors = 0, cmp_count = 0, seed = 32'h426b;
    mics_event_src i_src (.sys_clk, .reset_n, .req, .evt);
    mics_top i_dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .fault_dir(dir[0]), .reactive_sign_dir(dir[1]), .active_sign_dir(dir[2]),
        .fault_mode(lvl[0]), .reactive_power_negative(lvl[1]), .active_power_negative(lvl[2]),
        .active_noload_evt(evt[0]), .reactive_noload_evt(evt[1]), .apparent_noload_evt(evt[2]),
        .irms_noload_entry_evt(evt[3]), .active_halffull_evt(evt[4]),
        .reactive_halffull_evt(evt[5]), .apparent_halffull_evt(evt[6]),
        .active_overflow_evt(evt[7]), .reactive_overflow_evt(evt[8]),
        .apparent_overflow_evt(evt[9]), .pulse_out_one_evt(evt[10]),
        .pulse_out_two_evt(evt[11]), .zero_cross_evt(evt[12]), .zero_cross_timeout_evt(evt[13]),
        .cycle_end_evt(evt[14]), .voltage_peak_evt(evt[15]), .current_peak_evt(evt[16]),
        .waveform_load_evt(evt[17]), .soft_reset_done_evt(evt[18]), .tamper_select_b,
        .current_use_b, .voltage_ch_grounded, .current_ch_grounded, .metering_irq_pending);
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic hang();
        errors++;
        $display("mismatch bus answer expected 1 seen 0");
        close_out();
    endtask : hang
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (n < 40) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1 && s_axi_bready) begin
                chk("write response", 8'(er), 8'(s_axi_bresp));
                s_axi_bready <= 1'h0;
                n = 99;
            end else if (s_axi_bvalid === 1'h1) s_axi_bready <= 1'h1;
        end
        if (n != 99) hang();
    endtask : wr
    // ready is raised only once the answer shows, so holding of the answer is exercised
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what,
        input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        while (n < 40) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1 && s_axi_rready) begin
                chk(what, exp, s_axi_rdata[7:0]);
                chk("read upper", 8'h00, 8'(|s_axi_rdata[31:8]));
                chk("read response", 8'(er), 8'(s_axi_rresp));
                s_axi_rready <= 1'h0;
                n = 99;
            end else if (s_axi_rvalid === 1'h1) s_axi_rready <= 1'h1;
        end
        if (n != 99) hang();
    endtask : rd
    task automatic ev(input int i);
        @(posedge sys_clk);
        req <= 19'h00001 << i;
        @(posedge sys_clk);
        req <= '0;
        repeat (2) @(posedge sys_clk);
    endtask : ev
    task automatic pend(input logic e);
        @(negedge sys_clk);
        chk("pending", 8'(e), 8'(metering_irq_pending));
    endtask : pend
    function automatic logic [7:0] ev_bit(input int i);
        if (i == 3) return 8'h04;
        if (i == 18) return 8'h80;
        return 8'h01 << (i < 4 ? i : (i < 12 ? i - 4 : i - 12));
    endfunction : ev_bit
    function automatic logic [11:0] ev_addr(input int i);
        return i < 4 ? A_STL : (i < 12 ? A_STM : A_STH);
    endfunction : ev_addr
    initial begin
        int j;
        logic [7:0] lv;
        logic ub;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'h1;
        rd(A_STH, 8'h80, "reset done");
        rd(A_CAL, 8'h00, "cal reset");
        wr(A_STH, 8'h7F);
        rd(A_STH, 8'h00, "reset done clear");
        wr(A_ENL, 8'h3F);
        wr(A_ENM, 8'hFF);
        wr(A_ENH, 8'h3F);
        for (int i = 0; i < 19; i++) begin
            ev(i);
            if (i < 4) rd(A_STL, ev_bit(i) | 8'h80, "flag");
            else if (i < 12) rd(A_STM, ev_bit(i), "flag");
            else rd(A_STH, ev_bit(i), "flag");
            rd(A_STL, (i < 4 ? ev_bit(i) : 8'h00) | (i < 18 ? 8'h80 : 8'h00), "summary");
            pend(i < 18);
            wr(ev_addr(i), ~ev_bit(i));
            rd(ev_addr(i), 8'h00, "flag clear");
            pend(1'h0);
        end
        for (int k = 0; k < 6; k++) begin
            lv = (8'h20 >> (k / 2)) | 8'h80;
            @(posedge sys_clk);
            dir[k / 2] <= k[0];
            lvl[k / 2] <= 1'h1;
            repeat (2) @(posedge sys_clk);
            rd(A_STL, k[0] ? 8'h00 : lv, "level rise");
            wr(A_STL, 8'hC7);
            lvl[k / 2] <= 1'h0;
            repeat (2) @(posedge sys_clk);
            rd(A_STL, k[0] ? lv : 8'h00, "level fall");
            wr(A_STL, 8'hC7);
        end
        j = 4 + int'($unsigned($random(seed)) % 8);
        wr(A_ENM, 8'h00);
        ev(j);
        pend(1'h0);
        rd(A_STL, 8'h00, "masked summary");
        wr(A_ENM, 8'hFF);
        pend(1'h1);
        wr(A_STM, 8'h00);
        for (int k = 0; k < 16; k++) begin
            tamper_select_b <= 1'($random(seed));
            // reserved calibration bits are always written as zero
            wr(A_CAL, 8'(k) << 2);
            for (int t = 0; t < 2; t++) begin
                @(negedge sys_clk);
                ub = k / 4 == 2 || (k / 4 != 1 && tamper_select_b);
                chk("use b", 8'(ub), 8'(current_use_b));
                @(posedge sys_clk);
                tamper_select_b <= ~tamper_select_b;
            end
            chk("voltage ground", 8'(k[1]), 8'(voltage_ch_grounded));
            chk("current ground", 8'(k[0]), 8'(current_ch_grounded));
            rd(A_CAL, 8'(k) << 2, "cal readback");
        end
        // a write with its low strobe off must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(A_CAL, 8'h00);
        rd(A_CAL, 8'h3C, "strobe off");
        s_axi_wstrb <= 4'hF;
        // second hardware reset in mid-run
        reset_n <= 1'h0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'h1;
        rd(A_STH, 8'h80, "reset again");
        rd(A_CAL, 8'h00, "cal after reset");
        wr(12'h000, 8'($random(seed)), MICS_RESP_SLVERR);
        rd(12'h000, 8'h00, "unmapped read", MICS_RESP_SLVERR);
        close_out();
    end
endmodule : test_metering_irq_status_calibration_mode
`default_nettype wire
